// ==== rtl/operand_mode_pkg.sv ====
package operand_mode_pkg;
  localparam logic [4:0] CODE_MEMREL_FRAME = 5'h10;
  localparam logic [4:0] CODE_MEMREL_STATIC = 5'h12;
  localparam logic [4:0] CODE_RESERVED = 5'h13;
  localparam logic [4:0] CODE_IMMEDIATE = 5'h14;
  localparam logic [4:0] CODE_ABSOLUTE = 5'h15;
  localparam logic [4:0] CODE_LINK_INDIRECT = 5'h16;
  localparam logic [4:0] CODE_STACK_TOP = 5'h17;
  localparam logic [1:0] GRP_REGISTER = 2'h0;
  localparam logic [1:0] GRP_REG_RELATIVE = 2'h1;
  localparam logic [2:0] GRP_MEM_SPACE = 3'h6;
  localparam logic [2:0] GRP_SCALED_INDEX = 3'h7;
  localparam logic [1:0] BASE_FRAME = 2'h0;
  localparam logic [1:0] BASE_STACK = 2'h1;
  localparam logic [1:0] BASE_STATIC = 2'h2;
  localparam logic [1:0] BASE_PROGRAM = 2'h3;
  localparam logic [1:0] KIND_REG = 2'h0;
  localparam logic [1:0] KIND_MEM = 2'h1;
  localparam logic [1:0] KIND_IMM = 2'h2;
  localparam logic [1:0] KIND_NONE = 2'h3;
  localparam int STACK_SEL_BIT = 0;
  localparam logic [4:0] LINK_ENTRY_SHIFT = 5'h02;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [2:0] COUNT_ONE_BYTE = 3'h1;
  localparam logic [2:0] COUNT_TWO_BYTES = 3'h2;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_INDEX = 6'h02,
    ST_DECODE = 6'h04,
    ST_DISP1 = 6'h08,
    ST_MEMRD = 6'h10,
    ST_DISP2 = 6'h20
  } state_t;
endpackage

// ==== rtl/operand_mode_address_gen.sv ====
// Function
// - codes 0-7 name general or float register 0-7 directly, no address.
// - 8-15 add displacement to register; 24-27 to frame, stack, static, program.
// - 16-18 read pointer at disp1 plus base, then add disp2.
// - stack base is one of two stack pointers chosen by status word bit.
// - code 19 is reserved and flagged illegal.
// - code 20 takes the operand value from the instruction queue.
// - code 22 reads pointer from link table entry disp1, then adds disp2.
// - code 23 addresses top of selected stack, push on write, pop on read.
// - each request decodes one 5-bit general field; an instruction has up to two.
// - immediate rejected when written; no indexing of immediate or index base.
// - displacement and immediate bytes arrive most significant first.
`timescale 1ns/10ps
`default_nettype none
module operand_mode_address_gen (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [4:0] gen_code_i,
  input wire logic operand_write_i,
  input wire logic [1:0] op_size_i,
  input wire logic float_op_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic byte_last_i,
  output logic byte_ready_o,
  output logic [2:0] base_reg_sel_o,
  input wire logic [31:0] base_reg_val_i,
  output logic [2:0] index_reg_sel_o,
  input wire logic [31:0] index_reg_val_i,
  input wire logic [31:0] frame_pointer_i,
  input wire logic [31:0] stack_ptr_zero_i,
  input wire logic [31:0] stack_ptr_one_i,
  input wire logic [31:0] static_base_i,
  input wire logic [31:0] program_counter_i,
  input wire logic [31:0] link_table_base_i,
  input wire logic [15:0] processor_status_word_i,
  output logic mem_rd_req_o,
  output logic [31:0] mem_rd_addr_o,
  input wire logic mem_rd_ack_i,
  input wire logic [31:0] mem_rd_data_i,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output logic [1:0] op_kind_o,
  output logic [2:0] reg_num_o,
  output logic float_reg_o,
  output logic [31:0] effective_address_o,
  output logic [31:0] imm_value_o,
  output logic stack_push_o,
  output logic stack_pop_o
);
  logic rst_meta_r, rst_sync_b_r;
  operand_mode_pkg::state_t state_r, state_nxt;
  logic [4:0] mode_r;
  logic indexed_r, write_r, float_r, done_r, illegal_r, push_r, pop_r, float_reg_r, fin, bad;
  logic [1:0] scale_r, size_r, kind_r, fin_kind;
  logic [2:0] idx_reg_r, cnt_r, reg_num_r;
  logic [31:0] acc_r, disp1_r, ptr_r, ea_r, imm_r, fin_ea;

  // reset is released through two flops; only the second one is used
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_r <= 1'h0;
      rst_sync_b_r <= 1'h0;
    end
    else
    begin
      rst_meta_r <= 1'h1;
      rst_sync_b_r <= rst_meta_r;
    end
  end

  wire is_reg = (mode_r[4:3] == operand_mode_pkg::GRP_REGISTER);
  wire is_relreg = (mode_r[4:3] == operand_mode_pkg::GRP_REG_RELATIVE);
  wire is_memrel = (mode_r >= operand_mode_pkg::CODE_MEMREL_FRAME) && (mode_r <= operand_mode_pkg::CODE_MEMREL_STATIC);
  wire is_reserved = (mode_r == operand_mode_pkg::CODE_RESERVED);
  wire is_imm = (mode_r == operand_mode_pkg::CODE_IMMEDIATE);
  wire is_abs = (mode_r == operand_mode_pkg::CODE_ABSOLUTE);
  wire is_link = (mode_r == operand_mode_pkg::CODE_LINK_INDIRECT);
  wire is_top = (mode_r == operand_mode_pkg::CODE_STACK_TOP);
  wire is_index = (mode_r[4:2] == operand_mode_pkg::GRP_SCALED_INDEX);
  wire start_is_index = (gen_code_i[4:2] == operand_mode_pkg::GRP_SCALED_INDEX);

  // the status word picks user or interrupt stack for every stack-based mode
  wire stack_sel = processor_status_word_i[operand_mode_pkg::STACK_SEL_BIT];
  wire [31:0] stack_val = stack_sel ? stack_ptr_one_i : stack_ptr_zero_i;
  wire [31:0] dedicated_val = (mode_r[1:0] == operand_mode_pkg::BASE_FRAME) ? frame_pointer_i :
                              (mode_r[1:0] == operand_mode_pkg::BASE_STACK) ? stack_val :
                              (mode_r[1:0] == operand_mode_pkg::BASE_STATIC) ? static_base_i :
                              program_counter_i;
  wire [31:0] base_val = mode_r[4] ? dedicated_val : base_reg_val_i;
  wire [31:0] index_term = indexed_r ? (index_reg_val_i << scale_r) : operand_mode_pkg::WORD_RESET;
  wire [31:0] size_bytes = 32'h00000001 << size_r;
  // a push lowers the stack before the write, a pop reads at the current top
  wire [31:0] top_addr = write_r ? (stack_val - size_bytes) : stack_val;
  wire [31:0] ptr_addr = is_link ? (link_table_base_i + (disp1_r << operand_mode_pkg::LINK_ENTRY_SHIFT))
                                 : (disp1_r + dedicated_val);

  wire taking = byte_valid_i && byte_ready_o;
  wire [31:0] acc_nxt = {acc_r[23:0], byte_i};
  wire [2:0] cnt_nxt = cnt_r + 3'h1;
  // byte count sets the displacement width; longer fields keep the last four bytes
  wire [31:0] field_val = (cnt_nxt == operand_mode_pkg::COUNT_ONE_BYTE) ? {{24{acc_nxt[7]}}, acc_nxt[7:0]} :
                          (cnt_nxt == operand_mode_pkg::COUNT_TWO_BYTES) ? {{16{acc_nxt[15]}}, acc_nxt[15:0]} :
                          acc_nxt;

  assign byte_ready_o = (state_r == operand_mode_pkg::ST_INDEX) || (state_r == operand_mode_pkg::ST_DISP1) ||
                        (state_r == operand_mode_pkg::ST_DISP2);
  assign base_reg_sel_o = mode_r[2:0];
  assign index_reg_sel_o = idx_reg_r;
  assign mem_rd_req_o = (state_r == operand_mode_pkg::ST_MEMRD);
  assign mem_rd_addr_o = ptr_addr;
  assign busy_o = (state_r != operand_mode_pkg::ST_IDLE);

  always_comb
  begin
    state_nxt = state_r;
    fin = 1'h0;
    bad = 1'h0;
    fin_kind = operand_mode_pkg::KIND_MEM;
    fin_ea = operand_mode_pkg::WORD_RESET;
    unique case (state_r)
      operand_mode_pkg::ST_IDLE:
        if (start_i)
          state_nxt = start_is_index ? operand_mode_pkg::ST_INDEX : operand_mode_pkg::ST_DECODE;
      operand_mode_pkg::ST_INDEX:
        if (taking)
          state_nxt = operand_mode_pkg::ST_DECODE;
      operand_mode_pkg::ST_DECODE:
      begin
        state_nxt = operand_mode_pkg::ST_IDLE;
        if (is_reserved || (is_imm && write_r) || (indexed_r && (is_imm || is_index)))
          bad = 1'h1;
        else if (is_reg && !indexed_r)
        begin
          fin = 1'h1;
          fin_kind = operand_mode_pkg::KIND_REG;
        end
        else if (is_reg)
        begin
          // an indexed register base uses the register contents as the base address
          fin = 1'h1;
          fin_ea = base_reg_val_i + index_term;
        end
        else if (is_top)
        begin
          fin = 1'h1;
          fin_ea = top_addr + index_term;
        end
        else
          state_nxt = operand_mode_pkg::ST_DISP1;
      end
      operand_mode_pkg::ST_DISP1:
        if (taking && byte_last_i)
        begin
          if (is_imm)
          begin
            state_nxt = operand_mode_pkg::ST_IDLE;
            fin = 1'h1;
            fin_kind = operand_mode_pkg::KIND_IMM;
          end
          else if (is_memrel || is_link)
            state_nxt = operand_mode_pkg::ST_MEMRD;
          else
          begin
            state_nxt = operand_mode_pkg::ST_IDLE;
            fin = 1'h1;
            fin_ea = is_abs ? (field_val + index_term) : (field_val + base_val + index_term);
          end
        end
      operand_mode_pkg::ST_MEMRD:
        if (mem_rd_ack_i)
          state_nxt = operand_mode_pkg::ST_DISP2;
      operand_mode_pkg::ST_DISP2:
        if (taking && byte_last_i)
        begin
          state_nxt = operand_mode_pkg::ST_IDLE;
          fin = 1'h1;
          fin_ea = ptr_r + field_val + index_term;
        end
      default:
        state_nxt = operand_mode_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      state_r <= operand_mode_pkg::ST_IDLE;
      mode_r <= 5'h00;
      indexed_r <= 1'h0;
      scale_r <= 2'h0;
      idx_reg_r <= 3'h0;
      write_r <= 1'h0;
      size_r <= 2'h0;
      float_r <= 1'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if ((state_r == operand_mode_pkg::ST_IDLE) && start_i)
      begin
        mode_r <= gen_code_i;
        indexed_r <= start_is_index;
        scale_r <= gen_code_i[1:0];
        write_r <= operand_write_i;
        size_r <= op_size_i;
        float_r <= float_op_i;
      end
      else if ((state_r == operand_mode_pkg::ST_INDEX) && taking)
      begin
        mode_r <= byte_i[7:3];
        idx_reg_r <= byte_i[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      acc_r <= operand_mode_pkg::WORD_RESET;
      cnt_r <= 3'h0;
      disp1_r <= operand_mode_pkg::WORD_RESET;
      ptr_r <= operand_mode_pkg::WORD_RESET;
    end
    else
    begin
      if (taking && (state_r != operand_mode_pkg::ST_INDEX))
      begin
        acc_r <= byte_last_i ? operand_mode_pkg::WORD_RESET : acc_nxt;
        cnt_r <= byte_last_i ? 3'h0 : cnt_nxt;
      end
      if (taking && byte_last_i && (state_r == operand_mode_pkg::ST_DISP1))
      begin
        disp1_r <= field_val;
      end
      if ((state_r == operand_mode_pkg::ST_MEMRD) && mem_rd_ack_i)
      begin
        ptr_r <= mem_rd_data_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      done_r <= 1'h0;
      illegal_r <= 1'h0;
      push_r <= 1'h0;
      pop_r <= 1'h0;
      kind_r <= operand_mode_pkg::KIND_NONE;
      reg_num_r <= 3'h0;
      float_reg_r <= 1'h0;
      ea_r <= operand_mode_pkg::WORD_RESET;
      imm_r <= operand_mode_pkg::WORD_RESET;
    end
    else
    begin
      done_r <= fin || bad;
      illegal_r <= bad;
      push_r <= fin && is_top && write_r;
      pop_r <= fin && is_top && !write_r;
      if (fin || bad)
      begin
        kind_r <= bad ? operand_mode_pkg::KIND_NONE : fin_kind;
        reg_num_r <= mode_r[2:0];
        float_reg_r <= float_r && (fin_kind == operand_mode_pkg::KIND_REG);
        ea_r <= fin_ea;
        imm_r <= (fin_kind == operand_mode_pkg::KIND_IMM) ? acc_nxt : operand_mode_pkg::WORD_RESET;
      end
    end
  end

  assign done_o = done_r;
  assign illegal_o = illegal_r;
  assign stack_push_o = push_r;
  assign stack_pop_o = pop_r;
  assign op_kind_o = kind_r;
  assign reg_num_o = reg_num_r;
  assign float_reg_o = float_reg_r;
  assign effective_address_o = ea_r;
  assign imm_value_o = imm_r;
endmodule // operand_mode_address_gen
`default_nettype wire

// ==== test/operand_mode_address_gen_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module operand_mode_address_gen_checker (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [4:0] gen_code_i,
  input wire logic operand_write_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic illegal_o,
  input wire logic [1:0] op_kind_o,
  input wire logic [2:0] reg_num_o,
  input wire logic stack_push_o,
  input wire logic stack_pop_o,
  input wire logic mem_rd_req_o,
  input wire logic mem_rd_ack_i,
  input wire logic [31:0] mem_rd_addr_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  logic go;
  assign go = start_i && !busy_o;
  property p_reg;
    go && gen_code_i[4:3] == 2'h0 |-> ##2 done_o && op_kind_o == operand_mode_pkg::KIND_REG
      && reg_num_o == $past(gen_code_i[2:0], 2);
  endproperty
  a_reg: assert property (p_reg) else $error("register code not decoded in two cycles");
  property p_rsv;
    go && gen_code_i == 5'h13 |-> ##2 done_o && illegal_o && op_kind_o == operand_mode_pkg::KIND_NONE;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code accepted");
  property p_imm_wr;
    go && gen_code_i == 5'h14 && operand_write_i |-> ##2 done_o && illegal_o;
  endproperty
  a_imm_wr: assert property (p_imm_wr) else $error("written immediate not refused");
  property p_pop;
    go && gen_code_i == 5'h17 && !operand_write_i |-> ##2 stack_pop_o && !stack_push_o;
  endproperty
  a_pop: assert property (p_pop) else $error("stack read without pop");
  property p_push;
    stack_push_o |-> done_o && op_kind_o == operand_mode_pkg::KIND_MEM;
  endproperty
  a_push: assert property (p_push) else $error("push without memory result");
  property p_hold;
    mem_rd_req_o && !mem_rd_ack_i |=> mem_rd_req_o && $stable(mem_rd_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer read dropped or moved");
  property p_ack;
    mem_rd_req_o && mem_rd_ack_i |=> !mem_rd_req_o;
  endproperty
  a_ack: assert property (p_ack) else $error("pointer read kept after ack");
  property p_once;
    done_o |=> !done_o;
  endproperty
  a_once: assert property (p_once) else $error("done longer than one cycle");
  property p_ill;
    illegal_o |-> done_o && op_kind_o == operand_mode_pkg::KIND_NONE;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal flag without done");
  property p_busy;
    go |=> busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("start not taken");
  property p_free;
    done_o |-> !busy_o;
  endproperty
  a_free: assert property (p_free) else $error("still busy at done");
endmodule // operand_mode_address_gen_checker
bind operand_mode_address_gen operand_mode_address_gen_checker i_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .start_i(start_i), .gen_code_i(gen_code_i), .operand_write_i(operand_write_i), .busy_o(busy_o), .done_o(done_o),
  .illegal_o(illegal_o), .op_kind_o(op_kind_o), .reg_num_o(reg_num_o), .stack_push_o(stack_push_o),
  .stack_pop_o(stack_pop_o), .mem_rd_req_o(mem_rd_req_o), .mem_rd_ack_i(mem_rd_ack_i), .mem_rd_addr_o(mem_rd_addr_o));
`default_nettype wire

// ==== test/tb_operand_mode_address_gen.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_operand_mode_address_gen;
  typedef struct packed {logic [1:0] k; logic [31:0] ea, im; logic [2:0] rn; logic il, fl, pu, po;} exp_t;
  logic clk = 1'b0, rst_b = 1'b0, st = 1'b0, wr = 1'b0, fop = 1'b0, bv = 1'b0, bl = 1'b0, ack = 1'b0;
  logic [4:0] code = 5'h00;
  logic [1:0] sz = 2'h0;
  logic [7:0] bt = 8'h00;
  logic [15:0] processor_status_word = 16'h0000;
  logic [31:0] fp = '0, sp0 = '0, sp1 = '0, sb = '0, pc = '0, lt = '0, rdat = '0;
  logic [31:0] rf [8];
  wire logic [31:0] bval, ival, radr, ea, im;
  wire logic [2:0] bsel, isel, rn;
  wire logic [1:0] kind;
  wire logic brdy, req, busy, done, ill, fl, pu, po;
  exp_t eq[$];
  exp_t e;
  logic [7:0] bq[$];
  logic lq[$];
  int fail_count = 0;
  int cmp_count = 0;
  assign bval = rf[bsel];
  assign ival = rf[isel];
  always #50 clk = ~clk;
  operand_mode_address_gen i_dut (.clk_sys_i(clk), .rst_b_i(rst_b), .start_i(st), .gen_code_i(code),
    .operand_write_i(wr), .op_size_i(sz), .float_op_i(fop), .byte_valid_i(bv), .byte_i(bt), .byte_last_i(bl),
    .byte_ready_o(brdy), .base_reg_sel_o(bsel), .base_reg_val_i(bval), .index_reg_sel_o(isel),
    .index_reg_val_i(ival), .frame_pointer_i(fp), .stack_ptr_zero_i(sp0), .stack_ptr_one_i(sp1),
    .static_base_i(sb), .program_counter_i(pc), .link_table_base_i(lt), .processor_status_word_i(processor_status_word),
    .mem_rd_req_o(req), .mem_rd_addr_o(radr), .mem_rd_ack_i(ack), .mem_rd_data_i(rdat), .busy_o(busy),
    .done_o(done), .illegal_o(ill), .op_kind_o(kind), .reg_num_o(rn), .float_reg_o(fl),
    .effective_address_o(ea), .imm_value_o(im), .stack_push_o(pu), .stack_pop_o(po));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] mk(input logic [31:0] r, input int n);
    return n >= 4 ? r : r & ((32'h1 << (8 * n)) - 32'h1);
  endfunction
  function automatic logic [31:0] dv(input logic [31:0] r, input int n);
    return n == 1 ? {{24{r[7]}}, r[7:0]} : n == 2 ? {{16{r[15]}}, r[15:0]} : mk(r, n);
  endfunction
  task automatic put(input logic [31:0] r, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      bq.push_back(r[8 * i +: 8]);
      lq.push_back(i == 0);
    end
  endtask
  task automatic op(input logic [4:0] c, input logic w, input logic [7:0] ix, input int n1, input int n2);
    logic [31:0] r1, r2, p, d1, s, b, ma;
    logic [4:0] m;
    logic sc, tk, ak, dn;
    exp_t x;
    r1 = $urandom;
    r2 = $urandom;
    p = $urandom;
    tk = 1'b0;
    ak = 1'b0;
    dn = 1'b0;
    sc = c[4:2] == 3'h7;
    if (sc)
      put({24'h000000, ix}, 1);
    put(r1, n1);
    put(r2, n2);
    @(posedge clk);
    st <= 1'b1;
    code <= c;
    wr <= w;
    sz <= 2'($urandom);
    fop <= 1'($urandom);
    processor_status_word <= 16'($urandom);
    {fp, sp0, sp1, sb, pc, lt} <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    for (int i = 0; i < 8; i++)
      rf[i] <= $urandom;
    @(negedge clk);
    m = sc ? ix[7:3] : c;
    d1 = dv(r1, n1);
    s = processor_status_word[operand_mode_pkg::STACK_SEL_BIT] ? sp1 : sp0;
    b = m[4:3] == 2'h1 ? rf[m[2:0]] : m[1:0] == 2'h0 ? fp : m[1:0] == 2'h1 ? s : m[1:0] == 2'h2 ? sb : pc;
    ma = m == 5'h16 ? lt + (d1 << 2) : d1 + b;
    x.ea = d1 + b;
    if (m[4:3] == 2'h0)
      x.ea = sc ? rf[m[2:0]] : 32'h0;
    if (m inside {5'h10, 5'h11, 5'h12, 5'h16})
      x.ea = p + dv(r2, n2);
    if (m == 5'h15)
      x.ea = d1;
    if (m == 5'h17)
      x.ea = w ? s - (32'h1 << sz) : s;
    if (m == 5'h14)
      x.ea = 32'h0;
    if (sc)
      x.ea = x.ea + (rf[ix[2:0]] << c[1:0]);
    x.k = m[4:3] == 2'h0 && !sc ? operand_mode_pkg::KIND_REG : m == 5'h14 ? operand_mode_pkg::KIND_IMM
      : operand_mode_pkg::KIND_MEM;
    x.il = m == 5'h13 || (m == 5'h14 && (w || sc)) || (m[4:2] == 3'h7 && sc);
    x.k = x.il ? operand_mode_pkg::KIND_NONE : x.k;
    x.im = m == 5'h14 ? mk(r1, n1) : 32'h0;
    x.rn = m[2:0];
    x.fl = fop && x.k == operand_mode_pkg::KIND_REG;
    x.pu = m == 5'h17 && w;
    x.po = m == 5'h17 && !w;
    eq.push_back(x);
    for (int t = 0; t < 60 && !dn; t++)
    begin
      @(posedge clk);
      st <= t == 0; // held into the busy cycle, must be ignored
      if (tk)
      begin
        bq.pop_front();
        lq.pop_front();
      end
      if (tk || !bv)
        bv <= bq.size() > 0 && $urandom_range(2) > 0;
      bt <= bq.size() > 0 ? bq[0] : ~bt;
      bl <= lq.size() > 0 ? lq[0] : ~bl;
      ack <= ak && $urandom_range(1) > 0;
      rdat <= ak ? p : ~rdat;
      @(negedge clk);
      tk = bv && brdy;
      ak = req && !ack;
      dn = done;
      if (ak)
        chk(radr, ma);
    end
    chk(dn, 1'b1);
  endtask
  always @(negedge clk)
    if (done && eq.size() == 0)
      chk(1'b1, 1'b0);
    else if (done)
    begin
      e = eq.pop_front();
      chk(ill, e.il);
      chk(kind, e.k);
      chk(fl, e.fl);
      chk({pu, po}, {e.pu, e.po});
      if (!e.il)
        chk(ea, e.ea);
      if (!e.il)
        chk(im, e.im);
      if (e.k == operand_mode_pkg::KIND_REG)
        chk(rn, e.rn);
    end
  initial
  begin
    rf = '{default: '0};
    void'($urandom(95155));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++)
      op(5'(i), 1'b0, 8'h00, 0, 0);
    for (int i = 8; i < 16; i++)
      op(5'(i), 1'(i), 8'h00, i % 4 + 1, 0);
    for (int i = 24; i < 28; i++)
      op(5'(i), 1'b0, 8'h00, i % 4 + 1, 0);
    for (int i = 16; i < 19; i++)
      op(5'(i), 1'b0, 8'h00, i - 15, 19 - i);
    op(5'h13, 1'b0, 8'h00, 0, 0);
    op(5'h14, 1'b0, 8'h00, 4, 0);
    op(5'h14, 1'b0, 8'h00, 1, 0);
    op(5'h14, 1'b1, 8'h00, 0, 0);
    op(5'h15, 1'b0, 8'h00, 2, 0);
    op(5'h16, 1'b0, 8'h00, 1, 4);
    for (int i = 0; i < 6; i++)
      op(5'h17, 1'(i), 8'h00, 0, 0);
    op(5'h1C, 1'b0, 8'h55, 2, 0);
    op(5'h1D, 1'b0, 8'hC1, 1, 0);
    op(5'h1E, 1'b0, 8'hB6, 1, 1);
    op(5'h1F, 1'b1, 8'h2F, 0, 0);
    op(5'h1D, 1'b0, 8'hBB, 0, 0);
    op(5'h1C, 1'b0, 8'hA0, 0, 0);
    op(5'h1F, 1'b0, 8'hF1, 0, 0);
    repeat (3) @(posedge clk);
    close_out();
  end
  initial
  begin
    #2000000;
    fail_count++;
    close_out();
  end
endmodule // tb_operand_mode_address_gen
`default_nettype wire
